// >>> design/hbdw_pkg.sv
// Package: constants and carrier types for the host bus decode and wait block
package hbdw_pkg;

   // ----------------------------------------
   // I/O register offsets (low nibble of A)
   // ----------------------------------------
   localparam logic [3:0] IO_DATA_LO = 4'hc;
   localparam logic [3:0] IO_DATA_HI = 4'hd;
   localparam logic [3:0] IO_PTR_LO = 4'he;
   localparam logic [3:0] IO_PTR_HI = 4'hf;
   localparam logic [3:0] IO_CFG = 4'h2;
   localparam logic [3:0] IO_AUX = 4'h3;
   localparam logic [3:0] IO_EXT = 4'h7;

   // ----------------------------------------
   // Configuration register fields and reset
   // ----------------------------------------
   localparam int CFG_WAIT_BIT = 2;
   localparam int CFG_DECODE_BIT = 0;
   localparam int CFG_WIDE_BIT = 1;
   localparam int CFG_IOMAP_BIT = 3;
   localparam int CFG_AINC_BIT = 4;
   localparam logic [7:0] CFG_RESET = 8'h04;

   // ----------------------------------------
   // Address window widths
   // ----------------------------------------
   localparam int RAM_AW = 11;
   localparam int BLK128_LSB = 17;
   localparam int ROM8_LSB = 13;
   localparam int ROM16_LSB = 14;
   localparam int MEM_AW = 24;
   localparam int IO_AW = 16;

   // ----------------------------------------
   // Ready timing in crystal clocks
   // ----------------------------------------
   localparam logic [1:0] WAIT_SHORT = 2'h1;
   localparam logic [1:0] WAIT_LONG = 2'h2;

   // Host bus strobes and high-byte enable
   typedef struct packed {
      logic mem_rd_n;
      logic mem_wr_n;
      logic io_rd_n;
      logic io_wr_n;
      logic byte_hi_n;
   } hbdw_strobe_t;

   // Buffer RAM access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [RAM_AW-1:0] addr;
      logic [7:0] wdata;
   } hbdw_ram_req_t;

   typedef enum logic [1:0] {
      HBDW_LANE_NONE,
      HBDW_LANE_LO,
      HBDW_LANE_HI,
      HBDW_LANE_BOTH
   } hbdw_lane_t;

endpackage

// >>> design/hbdw_addr_latch.sv
// Transparent address latch stage, sampled on the system clock
`timescale 1ns/1ps
module hbdw_addr_latch #(
   parameter int AW = 24
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ale,
   input wire logic [AW-1:0] addr_in,
   output logic [AW-1:0] addr_out
);
   logic [AW-1:0] held_reg;

   // ----------------------------------------
   // Capture while enable high, hold after
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         held_reg <= '0;
      end else if (ale) begin
         held_reg <= addr_in;
      end
   end

   // Pass-through when enable high so ale tied high keeps live address
   assign addr_out = ale ? addr_in : held_reg;
endmodule

// >>> design/hbdw_ready_timer.sv
// Crystal-clock ready stretch counter
`timescale 1ns/1ps
module hbdw_ready_timer (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic crystal_tick,
   input wire logic start,
   input wire logic [1:0] periods,
   output logic busy
);
   logic [1:0] count_reg;

   // ----------------------------------------
   // Count whole crystal periods
   // ----------------------------------------
   // Start only from idle; a second strobe in one cycle cannot restart
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 2'h0;
      end else if (start && count_reg == 2'h0) begin
         count_reg <= periods;
      end else if (crystal_tick && count_reg != 2'h0) begin
         count_reg <= count_reg - 2'h1;
      end
   end

   assign busy = (count_reg != 2'h0);
endmodule

// >>> design/hbdw_host_port.sv
// Host expansion-bus decode, data lanes, pointer and wait logic
`timescale 1ns/1ps
// Behaviour
// - Address latches transparent on enable, hold otherwise
// - Memory mode, prom high, decode 0: 128K window
// - Otherwise memory window is 2K, prom driven
// - I/O mode prom window 8K or 16K
// - I/O mode decodes to A15, no memcs16
// - iocs16 only for pointer and data registers
// - Reset non-zero-wait; bit2 zero selects zero-wait
// - Wait bit one: ready low one crystal period
// - PROM reads: ready low two crystal periods
// - External register writes: two crystal periods
// - 8-bit mode: cs16 high, upper lane floats
// - 16-bit: memcs16 on RAM, 8-bit registers low lane
// - Pointer loads all bits on low byte write
// - 8-bit I/O: pointer selects byte at data port
// - 8-bit memory: A10-A0 select buffer byte
// - 16-bit I/O: pointer is word address
// - 16-bit I/O byte access; upper half increments
// - Increment one in 8-bit, two in 16-bit
// - Pointer high at 0F, low at 0E
module hbdw_host_port #(
   parameter logic [hbdw_pkg::IO_AW-1:4] IO_BASE = 12'h2e0,
   parameter logic [hbdw_pkg::MEM_AW-1:hbdw_pkg::RAM_AW] RAM_BASE = 13'h01a0,
   parameter logic [hbdw_pkg::MEM_AW-1:hbdw_pkg::ROM16_LSB] ROM_BASE = 10'h034,
   parameter int XTAL_DIV = 5
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic crystal_clock,
   input wire logic ale,
   input wire logic [hbdw_pkg::MEM_AW-1:0] addr,
   input wire hbdw_pkg::hbdw_strobe_t strobe,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_lo_oe,
   output logic data_hi_oe,
   input wire logic prom_window_enable_n,
   output logic mem_cs16_n,
   output logic io_cs16_n,
   output logic zero_wait_n,
   output logic io_ready,
   output logic prom_cs_n,
   output logic ext_reg_wr_n,
   output logic [hbdw_pkg::RAM_AW-1:0] pointer
);
   logic [hbdw_pkg::MEM_AW-1:0] la;
   logic [7:0] cfg_reg;
   logic [7:0] ptr_hi_reg;
   logic [hbdw_pkg::RAM_AW-1:0] ptr_reg;
   logic [7:0] ram [0:(1<<hbdw_pkg::RAM_AW)-1];
   logic [15:0] dout_reg;
   logic lo_oe_reg, hi_oe_reg;
   logic mcs_reg, ics_reg, ows_reg, rdy_reg, prom_reg, extw_reg;
   logic xtal_d_reg, xtal_q_reg;
   logic crystal_tick;
   logic cyc_prev_reg;
   logic io_cyc, mem_cyc, cyc_any, cyc_start;
   logic wide, iomap, ainc, decode, wait_on;
   logic io_hit, ram_hit, blk_hit, rom_hit, mem16_win, ext_hit;
   logic [3:0] ioff;
   logic busy;
   logic t_start;
   logic [1:0] t_per;
   hbdw_pkg::hbdw_lane_t lane;
   hbdw_pkg::hbdw_ram_req_t req_lo, req_hi;

   // ----------------------------------------
   // Address latch
   // ----------------------------------------
   hbdw_addr_latch #(.AW(hbdw_pkg::MEM_AW)) u_latch (
      .clock(clock),
      .rst_n(rst_n),
      .ale(ale),
      .addr_in(addr),
      .addr_out(la)
   );

   // ----------------------------------------
   // Configuration decode
   // ----------------------------------------
   assign wide = cfg_reg[hbdw_pkg::CFG_WIDE_BIT];
   assign iomap = cfg_reg[hbdw_pkg::CFG_IOMAP_BIT];
   assign ainc = cfg_reg[hbdw_pkg::CFG_AINC_BIT];
   assign decode = cfg_reg[hbdw_pkg::CFG_DECODE_BIT];
   assign wait_on = cfg_reg[hbdw_pkg::CFG_WAIT_BIT];

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // I/O decode uses A15..A4 only, so aliases above 64K also match
   assign ioff = la[3:0];
   assign io_hit = (la[hbdw_pkg::IO_AW-1:4] == IO_BASE);
   assign ram_hit = !iomap && (la[hbdw_pkg::MEM_AW-1:hbdw_pkg::RAM_AW] == RAM_BASE);
   // 128K block decoded from unlatched upper lines for early answer
   assign blk_hit = (addr[hbdw_pkg::MEM_AW-1:hbdw_pkg::BLK128_LSB]
                     == RAM_BASE[hbdw_pkg::MEM_AW-1:hbdw_pkg::BLK128_LSB]);
   // PROM: 8K unless I/O mode with decode bit set
   always_comb begin
      rom_hit = 1'b0;
      if (!prom_window_enable_n) begin
         if (iomap && decode) begin
            rom_hit = (la[hbdw_pkg::MEM_AW-1:hbdw_pkg::ROM16_LSB] == ROM_BASE);
         end else begin
            rom_hit = (la[hbdw_pkg::MEM_AW-1:hbdw_pkg::ROM8_LSB]
                       == {ROM_BASE, 1'b0});
         end
      end
   end
   // Window choice for memcs16
   assign mem16_win = (prom_window_enable_n && !decode) ? blk_hit : ram_hit;
   assign ext_hit = io_hit && (ioff == hbdw_pkg::IO_EXT);

   assign io_cyc = iomap && io_hit && (!strobe.io_rd_n || !strobe.io_wr_n);
   assign mem_cyc = (ram_hit || rom_hit) && (!strobe.mem_rd_n || !strobe.mem_wr_n);
   assign cyc_any = io_cyc || mem_cyc;
   assign cyc_start = cyc_any && !cyc_prev_reg;

   // Byte lanes from A0 and the high-byte enable
   always_comb begin
      lane = hbdw_pkg::HBDW_LANE_LO;
      if (wide) begin
         unique case ({la[0], strobe.byte_hi_n})
            2'b00: lane = hbdw_pkg::HBDW_LANE_BOTH;
            2'b01: lane = hbdw_pkg::HBDW_LANE_LO;
            2'b10: lane = hbdw_pkg::HBDW_LANE_HI;
            2'b11: lane = hbdw_pkg::HBDW_LANE_NONE;
         endcase
      end
   end

   // ----------------------------------------
   // Buffer RAM request formation
   // ----------------------------------------
   always_comb begin
      req_lo = '0;
      req_hi = '0;
      if (mem_cyc && ram_hit && cyc_start) begin
         req_lo.addr = wide ? {la[hbdw_pkg::RAM_AW-1:1], 1'b0} : la[hbdw_pkg::RAM_AW-1:0];
         req_hi.addr = {la[hbdw_pkg::RAM_AW-1:1], 1'b1};
         req_lo.rd = !strobe.mem_rd_n && lane != hbdw_pkg::HBDW_LANE_HI;
         req_lo.wr = !strobe.mem_wr_n && lane != hbdw_pkg::HBDW_LANE_HI;
         req_hi.rd = wide && !strobe.mem_rd_n && lane[1];
         req_hi.wr = wide && !strobe.mem_wr_n && lane[1];
         req_lo.wdata = data_in[7:0];
         req_hi.wdata = data_in[15:8];
      end else if (io_cyc && cyc_start && (ioff == hbdw_pkg::IO_DATA_LO || ioff == hbdw_pkg::IO_DATA_HI)) begin
         // Pointer addresses the buffer byte or word
         req_lo.addr = ptr_reg;
         req_hi.addr = ptr_reg + 11'h001;
         req_lo.rd = !strobe.io_rd_n && (!wide || lane == hbdw_pkg::HBDW_LANE_LO ||
                     lane == hbdw_pkg::HBDW_LANE_BOTH);
         req_lo.wr = !strobe.io_wr_n && (!wide || lane == hbdw_pkg::HBDW_LANE_LO ||
                     lane == hbdw_pkg::HBDW_LANE_BOTH);
         req_hi.rd = wide && !strobe.io_rd_n && lane[1];
         req_hi.wr = wide && !strobe.io_wr_n && lane[1];
         req_lo.wdata = data_in[7:0];
         req_hi.wdata = data_in[15:8];
      end
   end

   // ----------------------------------------
   // Buffer RAM storage
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (req_lo.wr) begin
         ram[req_lo.addr] <= req_lo.wdata;
      end
      if (req_hi.wr) begin
         ram[req_hi.addr] <= req_hi.wdata;
      end
   end

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= hbdw_pkg::CFG_RESET;
      end else if (io_hit && !strobe.io_wr_n && !cyc_prev_reg && ioff == hbdw_pkg::IO_CFG) begin
         cfg_reg <= data_in[7:0];
      end
   end

   // ----------------------------------------
   // Address pointer
   // ----------------------------------------
   // High byte waits in a holding register so the pointer never shows half a load
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr_hi_reg <= 8'h00;
         ptr_reg <= '0;
      end else if (io_cyc && !strobe.io_wr_n && cyc_start) begin
         if (ioff == hbdw_pkg::IO_PTR_HI && wide && lane == hbdw_pkg::HBDW_LANE_HI) begin
            ptr_hi_reg <= data_in[15:8];
         end else if (ioff == hbdw_pkg::IO_PTR_HI) begin
            ptr_hi_reg <= data_in[7:0];
         end else if (ioff == hbdw_pkg::IO_PTR_LO && lane == hbdw_pkg::HBDW_LANE_BOTH) begin
            ptr_hi_reg <= data_in[15:8];
            ptr_reg <= {data_in[10:8], data_in[7:0]};
         end else if (ioff == hbdw_pkg::IO_PTR_LO) begin
            ptr_reg <= {ptr_hi_reg[2:0], data_in[7:0]};
         end else if (ainc && (ioff == hbdw_pkg::IO_DATA_LO || ioff == hbdw_pkg::IO_DATA_HI)) begin
            if (!wide) begin
               ptr_reg <= ptr_reg + 11'h001;
            end else if (lane[1]) begin
               ptr_reg <= ptr_reg + 11'h002;
            end
         end
      end else if (io_cyc && !strobe.io_rd_n && cyc_start && ainc &&
                   (ioff == hbdw_pkg::IO_DATA_LO || ioff == hbdw_pkg::IO_DATA_HI)) begin
         if (!wide) begin
            ptr_reg <= ptr_reg + 11'h001;
         end else if (lane[1]) begin
            ptr_reg <= ptr_reg + 11'h002;
         end
      end
   end

   // ----------------------------------------
   // Read data and lane enables
   // ----------------------------------------
   // 8-bit registers and narrow mode use the low lane only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dout_reg <= 16'h0000;
         lo_oe_reg <= 1'b0;
         hi_oe_reg <= 1'b0;
      end else if (!cyc_any || (strobe.io_rd_n && strobe.mem_rd_n)) begin
         lo_oe_reg <= 1'b0;
         hi_oe_reg <= 1'b0;
      end else if (cyc_start) begin
         lo_oe_reg <= 1'b1;
         hi_oe_reg <= 1'b0;
         dout_reg <= 16'h0000;
         if (req_lo.rd || req_hi.rd) begin
            dout_reg <= {ram[req_hi.addr], ram[req_lo.addr]};
            lo_oe_reg <= req_lo.rd;
            hi_oe_reg <= req_hi.rd;
         end else if (io_cyc && ioff == hbdw_pkg::IO_CFG) begin
            dout_reg <= {8'h00, cfg_reg};
         end else if (io_cyc && (ioff == hbdw_pkg::IO_PTR_LO || ioff == hbdw_pkg::IO_PTR_HI)) begin
            dout_reg <= {5'h00, ptr_reg};
            if (wide && lane == hbdw_pkg::HBDW_LANE_HI) begin
               dout_reg <= {5'h00, ptr_reg[10:8], 8'h00};
               lo_oe_reg <= 1'b0;
               hi_oe_reg <= 1'b1;
            end else if (wide && lane == hbdw_pkg::HBDW_LANE_BOTH) begin
               hi_oe_reg <= 1'b1;
            end else if (ioff == hbdw_pkg::IO_PTR_HI) begin
               dout_reg <= {8'h00, 5'h00, ptr_reg[10:8]};
            end
         end
      end
   end

   // ----------------------------------------
   // 16-bit select outputs
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mcs_reg <= 1'b1;
         ics_reg <= 1'b1;
      end else begin
         // memcs16 never in I/O mode or narrow mode; iocs16 only in wide I/O mode
         mcs_reg <= !(wide && !iomap && mem16_win);
         ics_reg <= !(wide && iomap && io_hit && (ioff == hbdw_pkg::IO_PTR_LO ||
                   ioff == hbdw_pkg::IO_PTR_HI || ioff == hbdw_pkg::IO_DATA_LO ||
                   ioff == hbdw_pkg::IO_DATA_HI));
      end
   end

   // ----------------------------------------
   // PROM and external register strobes
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prom_reg <= 1'b1;
         extw_reg <= 1'b1;
      end else begin
         prom_reg <= !(rom_hit && !strobe.mem_rd_n);
         extw_reg <= !(ext_hit && !strobe.io_wr_n);
      end
   end

   // ----------------------------------------
   // Crystal clock edge detect
   // ----------------------------------------
   // Crystal pin taken as synchronous; one register delay then edge compare
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         xtal_d_reg <= 1'b0;
         xtal_q_reg <= 1'b0;
         cyc_prev_reg <= 1'b0;
      end else begin
         xtal_d_reg <= crystal_clock;
         xtal_q_reg <= xtal_d_reg;
         cyc_prev_reg <= cyc_any || (io_hit && !strobe.io_wr_n); // Config writes count in memory mode
      end
   end
   assign crystal_tick = xtal_d_reg && !xtal_q_reg;

   // ----------------------------------------
   // Ready stretch selection
   // ----------------------------------------
   always_comb begin
      t_per = hbdw_pkg::WAIT_SHORT;
      t_start = 1'b0;
      if (!cyc_prev_reg) begin
         if (!prom_window_enable_n && rom_hit && !strobe.mem_rd_n) begin
            t_per = hbdw_pkg::WAIT_LONG;
            t_start = 1'b1;
         end else if (ext_hit && !strobe.io_wr_n) begin
            t_per = hbdw_pkg::WAIT_LONG;
            t_start = 1'b1;
         end else if (cyc_any && wait_on) begin
            t_start = 1'b1;
         end
      end
   end

   hbdw_ready_timer u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .crystal_tick(crystal_tick),
      .start(t_start),
      .periods(t_per),
      .busy(busy)
   );

   // ----------------------------------------
   // Wait outputs
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ows_reg <= 1'b1;
         rdy_reg <= 1'b1;
      end else begin
         // Held off while ready is stretched, so both never show a wait at once
         ows_reg <= !(cyc_any && !wait_on && !rom_hit && !(ext_hit && !strobe.io_wr_n) && !busy && !t_start);
         rdy_reg <= !(busy || t_start);
      end
   end

   assign data_out = dout_reg;
   assign data_lo_oe = lo_oe_reg;
   assign data_hi_oe = hi_oe_reg;
   assign mem_cs16_n = mcs_reg;
   assign io_cs16_n = ics_reg;
   assign zero_wait_n = ows_reg;
   assign io_ready = rdy_reg;
   assign prom_cs_n = prom_reg;
   assign ext_reg_wr_n = extw_reg;
   assign pointer = ptr_reg;
endmodule

// >>> dv/hbdw_host_port_monitor.sv
// Checker: port-level decode, lane and wait relations of the host port
`timescale 1ns/1ps
module hbdw_host_port_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire hbdw_pkg::hbdw_strobe_t strobe,
   input wire logic data_lo_oe,
   input wire logic data_hi_oe,
   input wire logic mem_cs16_n,
   input wire logic io_cs16_n,
   input wire logic zero_wait_n,
   input wire logic io_ready,
   input wire logic prom_cs_n,
   input wire logic ext_reg_wr_n,
   input wire logic [hbdw_pkg::RAM_AW-1:0] pointer
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Bus idle for two cycles
   // ----------------------------------------
   sequence idle2;
      (&strobe[4:1]) [*2];
   endsequence

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   cs16_exclusive_a: assert property (!(!mem_cs16_n && !io_cs16_n))
      else $error("both cs16 outputs low");
   zero_wait_ready_a: assert property (!zero_wait_n |-> io_ready)
      else $error("ready low in zero wait");
   idle_wait_a: assert property (idle2 |-> io_ready && zero_wait_n)
      else $error("wait outputs active on idle bus");
   idle_lanes_a: assert property (idle2 |-> !data_lo_oe && !data_hi_oe)
      else $error("data lanes driven on idle bus");
   ready_bound_a: assert property ($fell(io_ready) |-> ##[1:40] io_ready)
      else $error("ready held low too long");
   hi_lane_read_a: assert property (data_hi_oe |-> $past(!strobe.io_rd_n || !strobe.mem_rd_n))
      else $error("upper lane driven without read");
   prom_read_a: assert property (!prom_cs_n |-> $past(!strobe.mem_rd_n))
      else $error("prom select without memory read");
   ext_write_a: assert property (!ext_reg_wr_n |-> $past(!strobe.io_wr_n))
      else $error("external strobe without io write");
   ptr_update_a: assert property ($changed(pointer) |-> $past(!strobe.io_wr_n || !strobe.io_rd_n))
      else $error("pointer moved without io access");
endmodule

bind hbdw_host_port hbdw_host_port_monitor mon_u (.clock(clock), .rst_n(rst_n), .strobe(strobe),
   .data_lo_oe(data_lo_oe), .data_hi_oe(data_hi_oe), .mem_cs16_n(mem_cs16_n), .io_cs16_n(io_cs16_n),
   .zero_wait_n(zero_wait_n), .io_ready(io_ready), .prom_cs_n(prom_cs_n), .ext_reg_wr_n(ext_reg_wr_n),
   .pointer(pointer));

// >>> dv/hbdw_host_model.sv
// Host processor model: bus cycles held until ready
`timescale 1ns/1ps
module hbdw_host_model (
   input wire logic clock,
   input wire logic io_ready,
   input wire logic [15:0] data_out,
   input wire logic [6:0] seen,
   output logic ale,
   output logic [hbdw_pkg::MEM_AW-1:0] addr,
   output hbdw_pkg::hbdw_strobe_t strobe,
   output logic [15:0] data_in
);
   logic [6:0] last;
   logic pulse_ale;

   // Idle bus; enable left high as most hosts tie it
   initial begin
      ale = 1'b1;
      addr = 24'h000000;
      strobe = 5'h1f;
      data_in = 16'h0000;
      pulse_ale = 1'b0;
      last = 7'h00;
   end

   // Address a cycle ahead, strobe held until ready is seen high
   task automatic access(input hbdw_pkg::hbdw_strobe_t s, input logic [23:0] a, input logic [15:0] wd,
         output logic [15:0] rd, output int lowc);
      int n;
      lowc = 0;
      @(posedge clock);
      addr <= a;
      data_in <= wd;
      @(posedge clock);
      strobe <= s;
      for (n = 0; n < 60; n++) begin
         @(posedge clock);
         if (pulse_ale && n == 1) begin
            ale <= 1'b0;
            addr <= a ^ 24'h0f07ff; // Leaves the RAM window, so only the latch keeps the cycle alive
         end
         // Only ready is wired, never the zero-wait line
         if (io_ready === 1'b0) lowc++;
         else if (n >= 2) break;
      end
      rd = data_out;
      last = seen;
      strobe <= 5'h1f;
      ale <= 1'b1;
      data_in <= ~wd;
   endtask
endmodule

// >>> dv/hbdw_host_port_tb_top.sv
// Testbench: host port decode, pointer, lane and wait checks
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; $display("Error at %0t: got %h expected %h", $time, a, e); end end
module hbdw_host_port_tb_top;
   localparam hbdw_pkg::hbdw_strobe_t IORD = 5'h1b, IOWR = 5'h1d, MRD = 5'h0f, MWR = 5'h17;
   localparam logic [3:0] CFG = hbdw_pkg::IO_CFG, PHI = hbdw_pkg::IO_PTR_HI, PLO = hbdw_pkg::IO_PTR_LO;
   localparam logic [3:0] DLO = hbdw_pkg::IO_DATA_LO, EXT = hbdw_pkg::IO_EXT;
   localparam logic [23:0] IOB = 24'h002e00;
   localparam int XC = 8; // crystal period in clocks
   logic clock, rst_n, crystal_clock, prom_window_enable_n, ale;
   logic [23:0] addr;
   hbdw_pkg::hbdw_strobe_t strobe;
   logic [15:0] data_in, data_out, rd;
   logic data_lo_oe, data_hi_oe, mem_cs16_n, io_cs16_n, zero_wait_n, io_ready, prom_cs_n, ext_reg_wr_n;
   logic [10:0] pointer;
   int lowc, bad_count, checks;

   hbdw_host_port #(.ROM_BASE(10'h030)) dut_u (.clock(clock), .rst_n(rst_n), .crystal_clock(crystal_clock),
      .ale(ale), .addr(addr), .strobe(strobe), .data_in(data_in), .data_out(data_out), .data_lo_oe(data_lo_oe),
      .data_hi_oe(data_hi_oe), .prom_window_enable_n(prom_window_enable_n), .mem_cs16_n(mem_cs16_n),
      .io_cs16_n(io_cs16_n), .zero_wait_n(zero_wait_n), .io_ready(io_ready), .prom_cs_n(prom_cs_n),
      .ext_reg_wr_n(ext_reg_wr_n), .pointer(pointer));
   hbdw_host_model host_u (.clock(clock), .io_ready(io_ready), .data_out(data_out),
      .seen({ext_reg_wr_n, prom_cs_n, mem_cs16_n, io_cs16_n, zero_wait_n, data_hi_oe, data_lo_oe}), .ale(ale),
      .addr(addr),
      .strobe(strobe), .data_in(data_in));

   // Clocks; crystal phase offset so it never lines up with the bus
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      crystal_clock = 1'b0;
      #3;
      forever #40 crystal_clock = ~crystal_clock;
   end

   task automatic io(input hbdw_pkg::hbdw_strobe_t s, input logic [3:0] off, input logic [15:0] wd);
      host_u.access(s, IOB | {20'h00000, off}, wd, rd, lowc);
   endtask
   task automatic mem(input hbdw_pkg::hbdw_strobe_t s, input logic [23:0] a, input logic [15:0] wd);
      host_u.access(s, a, wd, rd, lowc);
   endtask
   // High byte first, low byte commits
   task automatic ptr(input logic [15:0] v);
      io(IOWR, PHI, {8'h00, v[15:8]});
      io(IOWR, PLO, {8'h00, v[7:0]});
   endtask
   task automatic finish_test;
      if (bad_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run of under 1000 cycles
   initial begin
      #50000;
      bad_count++;
      finish_test;
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      bad_count = 0;
      checks = 0;
      rst_n = 1'b0;
      prom_window_enable_n = 1'b1;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      `CHK(({io_ready, zero_wait_n, mem_cs16_n, io_cs16_n, data_lo_oe, pointer}), 16'hf000)
      // 8-bit I/O mode with auto increment
      io(IOWR, CFG, 16'h001c);
      io(IOWR, PHI, 16'h0003);
      `CHK(pointer, 11'h000)
      io(IOWR, PLO, 16'h0010);
      `CHK(pointer, 11'h310)
      io(IOWR, DLO, 16'h00a5);
      `CHK(pointer, 11'h311)
      `CHK((lowc >= 1 && lowc <= XC + 3), 1'b1)
      ptr(16'h0310);
      io(IORD, DLO, 16'h0000);
      `CHK(rd[7:0], 8'ha5)
      `CHK(host_u.last[4:0], 5'h1d)
      io(IOWR, EXT, 16'h0055);
      `CHK((lowc >= XC && lowc <= 2 * XC + 3), 1'b1)
      `CHK(host_u.last[6], 1'b0)
      // 16-bit I/O mode, word pointer and data
      io(IOWR, CFG, 16'h001e);
      io(IOWR & 5'h1e, PLO, 16'h0420);
      `CHK(pointer, 11'h420)
      `CHK(host_u.last[3], 1'b0)
      io(IOWR & 5'h1e, DLO, 16'hbeef);
      `CHK(pointer, 11'h422)
      io(IOWR, DLO, 16'h0011);
      `CHK(pointer, 11'h422)
      io(IOWR & 5'h1e, PLO, 16'h0420);
      io(IORD & 5'h1e, DLO, 16'h0000);
      `CHK(rd, 16'hbeef)
      `CHK(host_u.last[4:0], 5'h17)
      io(IORD, CFG, 16'h0000);
      `CHK(host_u.last[3:1], 3'h6)
      mem(IORD, 24'h00ae02, 16'h0000);
      `CHK(host_u.last[1:0], 2'h0)
      // Zero wait state
      io(IOWR, CFG, 16'h001a);
      io(IORD, CFG, 16'h0000);
      `CHK(lowc, 0)
      `CHK(host_u.last[2], 1'b0)
      // Memory mode: wide window, then narrow window
      io(IOWR, CFG, 16'h0006);
      mem(MRD, 24'h0c0000, 16'h0000);
      `CHK(host_u.last[4], 1'b0)
      io(IOWR, CFG, 16'h0007);
      mem(MRD, 24'h0c0000, 16'h0000);
      `CHK(host_u.last[4], 1'b1)
      mem(MWR & 5'h1e, 24'h0d0002, 16'h1234);
      `CHK(host_u.last[4], 1'b0)
      mem(MRD & 5'h1e, 24'h0d0002, 16'h0000);
      `CHK(rd, 16'h1234)
      // 8-bit memory; read address scrambled after latching
      io(IOWR, CFG, 16'h0004);
      mem(MWR, 24'h0d0005, 16'h005a);
      host_u.pulse_ale <= 1'b1;
      mem(MRD, 24'h0d0005, 16'h0000);
      `CHK(rd[7:0], 8'h5a)
      `CHK(host_u.last[4:0], 5'h1d)
      host_u.pulse_ale <= 1'b0;
      // PROM window in memory and I/O modes
      io(IOWR, CFG, 16'h0006);
      prom_window_enable_n <= 1'b0;
      mem(MRD, 24'h0c0000, 16'h0000);
      `CHK(host_u.last[5:4], 2'h1)
      `CHK((lowc >= XC && lowc <= 2 * XC + 3), 1'b1)
      io(IOWR, CFG, 16'h000e);
      mem(MRD, 24'h0c2000, 16'h0000);
      `CHK(host_u.last[5], 1'b1)
      io(IOWR, CFG, 16'h000f);
      mem(MRD, 24'h0c2000, 16'h0000);
      `CHK(host_u.last[5:4], 2'h1)
      prom_window_enable_n <= 1'b1;
      mem(MRD, 24'h0c0000, 16'h0000);
      `CHK(host_u.last[5], 1'b1)
      finish_test;
   end
endmodule
